// ---- design/mel_pkg.sv ----
// Package of offsets, field layouts and reset values for the memory error logger
package mel_pkg;

	// Bus geometry: printed offsets are register indices, byte address is index times four
	localparam int          APB_DW   = 32;
	localparam int          ADDR_W   = 12;
	localparam int          ADDR_LSB = 2;
	localparam int          IDX_W    = ADDR_W - ADDR_LSB;

	localparam logic [IDX_W-1:0] IDX_BUF_MCE = 10'h07E;
	localparam logic [IDX_W-1:0] IDX_FIRST   = 10'h080;
	localparam logic [IDX_W-1:0] IDX_NEXT    = 10'h082;
	localparam logic [IDX_W-1:0] IDX_MASK    = 10'h084;
	localparam logic [IDX_W-1:0] IDX_THRESH  = 10'h098;

	// Field widths
	localparam int          BUF_W    = 4;
	localparam int          REG8_W   = 8;
	localparam int          EV_W     = 8;
	localparam int          LOG_W    = 16;
	localparam int          THR_W    = 16;

	// Reset values
	localparam logic [REG8_W-1:0] RST_BUF_MCE = 8'h00;
	localparam logic [LOG_W-1:0]  RST_LOG     = 16'h0000;
	localparam logic [EV_W-1:0]   RST_MASK    = 8'h00;
	localparam logic [THR_W-1:0]  RST_THRESH  = 16'h0000;
	localparam logic [EV_W-1:0]   EV_NONE     = 8'h00;
	localparam logic [APB_DW-1:0] RD_ZERO     = 32'h0000_0000;

	// Enable bit that gates each buffer flag (crossed for flags 0 and 1)
	localparam int          MCE_EN_FOR_FLAG0 = 1;
	localparam int          MCE_EN_FOR_FLAG1 = 0;
	localparam int          MCE_EN_FOR_FLAG2 = 2;
	localparam int          MCE_EN_FOR_FLAG3 = 3;

	// Event classes, same bit in the mask and in each channel half of the logs
	localparam int          EV_CORR_READ   = 0;
	localparam int          EV_UNCORR_READ = 1;
	localparam int          EV_SCRUB_ERR   = 2;
	localparam int          EV_THRESHOLD   = 3;
	localparam int          EV_COPY_DONE   = 4;
	localparam int          EV_RETRY       = 5;
	localparam int          EV_POISON_WR   = 6;
	localparam int          EV_TEST_DONE   = 7;

	// Bus slave states, Gray along idle to access
	typedef enum logic [1:0] {
		MEL_IDLE   = 2'b00,
		MEL_ACCESS = 2'b01
	} mel_state_e;

endpackage

// ---- design/mel_memory_error_logging.sv ----
// Memory error logging registers with APB slave and machine-check output
//
// Contract
// - Machine check when enabled buffer flag set
// - Enables 3,2 gate flags 3,2; rest reserved
// - Enable 1 gates flag 0, 0 gates 1
// - First-error log captures first event only
// - Later events go to next-error log
// - No new first bits until cleared
// - Same-cycle events all latch in first
// - Logs sticky, write one clears, zero keeps
// - Test complete sets bit 15 / 7
// - Poisoned write sets bit 14 / 6
// - Retry start sets bit 13 / 5
// - Sparing copy done sets bit 12 / 4
// - Threshold detect sets bit 11 / 3
// - Scrubber uncorrectable sets bit 10 / 2
// - Demand read uncorrectable sets bit 9 / 1
// - Corrected read sets bit 8 / 0
// - Next log uses first log layout
// - Mask bit blocks event recognition entirely
// - Mask covers both channels, sticky, reset zero
// - Mask bit order matches event classes
// - Threshold event when counter exceeds threshold
`timescale 1ns/100ps

module mel_memory_error_logging
	import mel_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              power_on_rst_n,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [APB_DW-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [APB_DW-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [BUF_W-1:0]  buffer_first_error_log,
	input  wire logic [BUF_W-1:0]  buffer_next_error_log,
	input  wire logic [EV_W-1:0]   chan_a_event,
	input  wire logic [EV_W-1:0]   chan_b_event,
	input  wire logic [THR_W-1:0]  chan_a_sec_count,
	input  wire logic [THR_W-1:0]  chan_b_sec_count,
	output logic                   machine_check_error_out
);

	mel_state_e        state;
	logic [REG8_W-1:0] buffer_machine_check_enable;
	logic [LOG_W-1:0]  memory_first_error_log;
	logic [LOG_W-1:0]  memory_next_error_log;
	logic [EV_W-1:0]   memory_error_mask;
	logic [THR_W-1:0]  sec_threshold;
	logic              over_a;
	logic              over_b;
	logic [IDX_W-1:0]  idx;
	logic              hit_mce;
	logic              hit_first;
	logic              hit_next;
	logic              hit_mask;
	logic              hit_thr;
	logic              hit_any;
	logic              wr_en;
	logic [LOG_W-1:0]  wr_lanes;
	logic [LOG_W-1:0]  first_clr;
	logic [LOG_W-1:0]  next_clr;
	logic [EV_W-1:0]   ev_a;
	logic [EV_W-1:0]   ev_b;
	logic [LOG_W-1:0]  raw_events;
	logic              first_empty;
	logic [LOG_W-1:0]  next_first;
	logic [LOG_W-1:0]  next_next;
	logic [BUF_W-1:0]  buf_flags;
	logic [BUF_W-1:0]  buf_gate;
	logic              next_mce;
	logic [APB_DW-1:0] next_rdata;

	// Address decode
	assign idx       = paddr[ADDR_W-1:ADDR_LSB];
	assign hit_mce   = (idx == IDX_BUF_MCE);
	assign hit_first = (idx == IDX_FIRST);
	assign hit_next  = (idx == IDX_NEXT);
	assign hit_mask  = (idx == IDX_MASK);
	assign hit_thr   = (idx == IDX_THRESH);
	assign hit_any   = hit_mce | hit_first | hit_next | hit_mask | hit_thr;

	// Ready only once read data was sampled for this transfer
	assign pready = clk_en & penable & (state == MEL_ACCESS);
	assign wr_en  = psel & penable & pwrite & pready;
	assign wr_lanes = {{EV_W{pstrb[1]}}, {EV_W{pstrb[0]}}};

	// Write-one-to-clear strobes, only the enabled byte lanes clear
	assign first_clr = (wr_en && hit_first) ? (pwdata[LOG_W-1:0] & wr_lanes) : RST_LOG;
	assign next_clr  = (wr_en && hit_next) ? (pwdata[LOG_W-1:0] & wr_lanes) : RST_LOG;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= MEL_IDLE;
		end else if (clk_en) begin
			case (state)
				MEL_IDLE: begin
					if (psel) begin
						state <= MEL_ACCESS;
					end
				end
				MEL_ACCESS: begin
					if (penable) begin
						state <= MEL_IDLE;
					end
				end
				default: begin
					state <= MEL_IDLE;
				end
			endcase
		end
	end

	// Read mux; reserved and unused upper bits return zero
	always_comb begin
		next_rdata = RD_ZERO;
		if (hit_mce) begin
			next_rdata[REG8_W-1:0] = buffer_machine_check_enable;
		end else if (hit_first) begin
			next_rdata[LOG_W-1:0] = memory_first_error_log;
		end else if (hit_next) begin
			next_rdata[LOG_W-1:0] = memory_next_error_log;
		end else if (hit_mask) begin
			next_rdata[EV_W-1:0] = memory_error_mask;
		end else if (hit_thr) begin
			next_rdata[THR_W-1:0] = sec_threshold;
		end
	end

	// Data sampled in setup; a flag arriving between setup and access shows on the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= RD_ZERO;
			pslverr <= 1'b0;
		end else if (clk_en && psel && state == MEL_IDLE) begin
			prdata  <= next_rdata;
			pslverr <= ~hit_any;
		end
	end

	// Enable register; only low nibble has storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_machine_check_enable <= RST_BUF_MCE;
		end else if (clk_en && wr_en && hit_mce && pstrb[0]) begin
			buffer_machine_check_enable <= {{(REG8_W-BUF_W){1'b0}}, pwdata[BUF_W-1:0]};
		end
	end

	// Mask and threshold survive bus reset, cleared only at power-on
	always_ff @(posedge pclk or negedge power_on_rst_n) begin
		if (!power_on_rst_n) begin
			memory_error_mask <= RST_MASK;
		end else if (clk_en && wr_en && hit_mask && pstrb[0]) begin
			memory_error_mask <= pwdata[EV_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge power_on_rst_n) begin
		if (!power_on_rst_n) begin
			sec_threshold <= RST_THRESH;
		end else if (clk_en && wr_en && hit_thr) begin
			if (pstrb[0]) begin
				sec_threshold[EV_W-1:0] <= pwdata[EV_W-1:0];
			end
			if (pstrb[1]) begin
				sec_threshold[THR_W-1:EV_W] <= pwdata[THR_W-1:EV_W];
			end
		end
	end

	// Threshold crossing is edge detected so one excursion logs once
	// Edge state is sticky like the threshold: a bus reset gives no false crossing
	always_ff @(posedge pclk or negedge power_on_rst_n) begin
		if (!power_on_rst_n) begin
			over_a <= 1'b0;
			over_b <= 1'b0;
		end else if (clk_en) begin
			over_a <= (chan_a_sec_count > sec_threshold);
			over_b <= (chan_b_sec_count > sec_threshold);
		end
	end

	// Event vectors per channel, masked before they are ever recognised
	always_comb begin
		ev_a = chan_a_event;
		ev_b = chan_b_event;
		ev_a[EV_THRESHOLD] = chan_a_event[EV_THRESHOLD] |
			((chan_a_sec_count > sec_threshold) & ~over_a);
		ev_b[EV_THRESHOLD] = chan_b_event[EV_THRESHOLD] |
			((chan_b_sec_count > sec_threshold) & ~over_b);
		raw_events = {ev_b & ~memory_error_mask, ev_a & ~memory_error_mask};
	end

	// Channel B high byte, channel A low byte, one class per bit
	assign first_empty = (memory_first_error_log == RST_LOG);

	always_comb begin
		next_first = memory_first_error_log & ~first_clr;
		next_next  = memory_next_error_log & ~next_clr;
		if (first_empty) begin
			next_first = next_first | raw_events;
		end else begin
			next_next = next_next | raw_events;
		end
	end

	// Logs survive bus reset; set wins over a same-cycle clear
	always_ff @(posedge pclk or negedge power_on_rst_n) begin
		if (!power_on_rst_n) begin
			memory_first_error_log <= RST_LOG;
			memory_next_error_log  <= RST_LOG;
		end else if (clk_en) begin
			memory_first_error_log <= next_first;
			memory_next_error_log  <= next_next;
		end
	end

	// Machine check from buffer flags, crossed enables on flags 0 and 1
	always_comb begin
		buf_flags   = buffer_first_error_log | buffer_next_error_log;
		buf_gate[0] = buffer_machine_check_enable[MCE_EN_FOR_FLAG0];
		buf_gate[1] = buffer_machine_check_enable[MCE_EN_FOR_FLAG1];
		buf_gate[2] = buffer_machine_check_enable[MCE_EN_FOR_FLAG2];
		buf_gate[3] = buffer_machine_check_enable[MCE_EN_FOR_FLAG3];
		next_mce    = |(buf_flags & buf_gate);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			machine_check_error_out <= 1'b0;
		end else if (clk_en) begin
			machine_check_error_out <= next_mce;
		end
	end

	default clocking mel_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !power_on_rst_n);

	mce_cross_a: assert property (
		(clk_en && buffer_first_error_log[0] && buffer_machine_check_enable[1])
		|=> machine_check_error_out)
		else $error("flag 0 with enable 1 gave no machine check");

	mce_quiet_a: assert property (
		(clk_en && (buffer_machine_check_enable[BUF_W-1:0] == 4'h0))
		|=> !machine_check_error_out)
		else $error("machine check raised with all enables clear");

	mce_direct_a: assert property (
		(clk_en && buffer_next_error_log[3] && buffer_machine_check_enable[3])
		|=> machine_check_error_out)
		else $error("flag 3 with enable 3 gave no machine check");

	rsvd_zero_a: assert property (
		buffer_machine_check_enable[REG8_W-1:BUF_W] == 4'h0)
		else $error("reserved enable bits not zero");

	first_latch_a: assert property (
		(clk_en && first_empty && raw_events != RST_LOG && first_clr == RST_LOG)
		|=> memory_first_error_log == $past(raw_events))
		else $error("first log did not latch all same-cycle events");

	first_hold_a: assert property (
		(clk_en && !first_empty)
		|=> (memory_first_error_log & ~$past(memory_first_error_log)) == RST_LOG)
		else $error("new bit set in occupied first log");

	next_log_a: assert property (
		(clk_en && !first_empty && raw_events != RST_LOG)
		|=> (memory_next_error_log & $past(raw_events)) == $past(raw_events))
		else $error("later event not logged in next log");

	w1c_keep_a: assert property (
		(clk_en && wr_en && hit_first)
		|=> (memory_first_error_log & $past(memory_first_error_log & ~first_clr))
			== $past(memory_first_error_log & ~first_clr))
		else $error("zero write cleared a first log bit");

	mask_block_a: assert property (
		clk_en |=> ((memory_first_error_log | memory_next_error_log)
			& ~$past(memory_first_error_log | memory_next_error_log)
			& {$past(memory_error_mask), $past(memory_error_mask)}) == RST_LOG)
		else $error("masked event was logged");

	thresh_ev_a: assert property (
		(clk_en && chan_a_sec_count > sec_threshold && !over_a
			&& !memory_error_mask[EV_THRESHOLD])
		|-> raw_events[EV_THRESHOLD])
		else $error("threshold crossing not recognised");

	ready_bound_a: assert property (
		(psel && !penable && clk_en) |=> ##[0:8] (pready || !clk_en))
		else $error("no ready after setup");

	bus_access_a: assert property (
		(clk_en && psel && !penable && state == MEL_IDLE) |=> (state == MEL_ACCESS))
		else $error("setup did not lead to access state");

	idle_ready_a: assert property (
		(state == MEL_IDLE) |-> !pready)
		else $error("ready raised outside access");

	unmapped_err_a: assert property (
		(clk_en && psel && state == MEL_IDLE && !hit_any) |=> pslverr)
		else $error("unmapped access gave no error");

	unmapped_zero_a: assert property (
		(clk_en && psel && state == MEL_IDLE && !hit_any) |=> (prdata == RD_ZERO))
		else $error("unmapped read returned data");

	first_read_a: assert property (
		(clk_en && psel && state == MEL_IDLE && hit_first)
		|=> prdata[LOG_W-1:0] == $past(memory_first_error_log))
		else $error("first log read data wrong");

	upper_zero_a: assert property (
		prdata[APB_DW-1:LOG_W] == 16'h0000)
		else $error("upper read data not zero");

	mask_write_a: assert property (
		(wr_en && hit_mask && pstrb[0]) |=> memory_error_mask == $past(pwdata[EV_W-1:0]))
		else $error("mask write not taken");

	first_clear_a: assert property (
		(clk_en && wr_en && hit_first)
		|=> (memory_first_error_log & $past(first_clr) & ~$past(raw_events)) == RST_LOG)
		else $error("first log bit not cleared by one");

	next_clear_a: assert property (
		(clk_en && wr_en && hit_next)
		|=> (memory_next_error_log & $past(next_clr) & ~$past(raw_events)) == RST_LOG)
		else $error("next log bit not cleared by one");

	next_idle_a: assert property (
		(clk_en && first_empty)
		|=> (memory_next_error_log & ~$past(memory_next_error_log)) == RST_LOG)
		else $error("next log set while first log empty");

	mce_none_a: assert property (
		(clk_en && (buffer_first_error_log | buffer_next_error_log) == 4'h0)
		|=> !machine_check_error_out)
		else $error("machine check raised with no buffer flag");

	mce_flag1_a: assert property (
		(clk_en && buffer_first_error_log[1] && buffer_machine_check_enable[0])
		|=> machine_check_error_out)
		else $error("flag 1 with enable 0 gave no machine check");

	// Masked traffic must be seen for the mask to mean anything
	mask_c: cover property (clk_en && (chan_a_event & memory_error_mask) != EV_NONE);

	first_cap_c: cover property (first_empty && clk_en && raw_events != RST_LOG);
	next_cap_c: cover property (!first_empty && clk_en && raw_events != RST_LOG);
	clear_c: cover property (wr_en && hit_first && first_clr != RST_LOG);
	mce_c: cover property (machine_check_error_out);

endmodule

// ---- verif/mel_event_source.sv ----
// Model of the memory channels and buffer feeding the logger
`timescale 1ns/100ps
module mel_event_source
	import mel_pkg::*;
(
	input  wire logic             pclk,
	output logic      [EV_W-1:0]  ev_a,
	output logic      [EV_W-1:0]  ev_b,
	output logic      [BUF_W-1:0] buf_first,
	output logic      [BUF_W-1:0] buf_next,
	output logic      [THR_W-1:0] count_a,
	output logic      [THR_W-1:0] count_b
);
	initial begin
		ev_a = EV_NONE;
		ev_b = EV_NONE;
		buf_first = '0;
		buf_next = '0;
		count_a = '0;
		count_b = '0;
	end
	// One cycle only, each high cycle counts as a new event
	task pulse(input logic [EV_W-1:0] a, input logic [EV_W-1:0] b);
		@(posedge pclk);
		ev_a <= a;
		ev_b <= b;
		@(posedge pclk);
		ev_a <= EV_NONE;
		ev_b <= EV_NONE;
		@(posedge pclk);
	endtask
	task set_buf(input logic [BUF_W-1:0] f, input logic [BUF_W-1:0] n);
		@(posedge pclk);
		buf_first <= f;
		buf_next <= n;
		@(posedge pclk);
	endtask
	task set_count(input logic [THR_W-1:0] a, input logic [THR_W-1:0] b);
		@(posedge pclk);
		count_a <= a;
		count_b <= b;
		@(posedge pclk);
		@(posedge pclk);
	endtask
endmodule

// ---- verif/memory_error_logging_bench.sv ----
// Self-checking bench for the memory error logger
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module memory_error_logging_bench
	import mel_pkg::*;
;
	localparam logic [ADDR_W-1:0] A_MCE = {IDX_BUF_MCE, 2'b00};
	localparam logic [ADDR_W-1:0] A_FST = {IDX_FIRST, 2'b00};
	localparam logic [ADDR_W-1:0] A_NXT = {IDX_NEXT, 2'b00};
	localparam logic [ADDR_W-1:0] A_MSK = {IDX_MASK, 2'b00};
	localparam logic [ADDR_W-1:0] A_THR = {IDX_THRESH, 2'b00};
	localparam logic [ADDR_W-1:0] A_BAD = 12'hFFC;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              por_n = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0;
	logic [APB_DW-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              mce;
	logic [EV_W-1:0]   ev_a;
	logic [EV_W-1:0]   ev_b;
	logic [BUF_W-1:0]  bf;
	logic [BUF_W-1:0]  bn;
	logic [THR_W-1:0]  ca;
	logic [THR_W-1:0]  cb;
	int                mismatches = 0;
	int                checks = 0;
	always #2 pclk = ~pclk;
	mel_event_source u_src (.pclk(pclk), .ev_a(ev_a), .ev_b(ev_b), .buf_first(bf),
		.buf_next(bn), .count_a(ca), .count_b(cb));
	mel_memory_error_logging DUT (.pclk(pclk), .presetn(presetn), .power_on_rst_n(por_n),
		.clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .buffer_first_error_log(bf), .buffer_next_error_log(bn),
		.chan_a_event(ev_a), .chan_b_event(ev_b), .chan_a_sec_count(ca),
		.chan_b_sec_count(cb), .machine_check_error_out(mce));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Ready is read right after the edge, before its flops update
	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [APB_DW-1:0] d,
		output logic [APB_DW-1:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1)
			mismatches++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [APB_DW-1:0] d);
		logic [APB_DW-1:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input string nm, input logic [ADDR_W-1:0] a, input logic [APB_DW-1:0] x);
		logic [APB_DW-1:0] r;
		logic e;
		apb(1'b0, a, RD_ZERO, r, e);
		`CHK(nm, x, r)
	endtask
	task mce_is(input logic x);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		`CHK("mce", x, mce)
	endtask
	task t_reset;
		logic [APB_DW-1:0] r;
		logic e;
		rd("mce_en", A_MCE, 32'h0);
		rd("first", A_FST, 32'h0);
		rd("next", A_NXT, 32'h0);
		rd("mask", A_MSK, 32'h0);
		apb(1'b0, A_BAD, RD_ZERO, r, e);
		`CHK("unmapped err", 1'b1, e)
		wr(A_MCE, 32'hFF);
		rd("mce_en rsvd", A_MCE, 32'h0F);
	endtask
	task t_mce;
		int en[4] = '{1, 0, 2, 3};
		for (int i = 0; i < 4; i++) begin
			u_src.set_buf(4'h1 << i, 4'h0);
			wr(A_MCE, ~(32'h1 << en[i]) & 32'hF);
			mce_is(1'b0);
			wr(A_MCE, 32'h1 << en[i]);
			mce_is(1'b1);
			u_src.set_buf(4'h0, 4'h1 << i);
			mce_is(1'b1);
			u_src.set_buf(4'h0, 4'h0);
			mce_is(1'b0);
		end
	endtask
	task t_events;
		for (int k = 0; k < 8; k++) begin
			u_src.pulse(8'h1 << k, 8'h0);
			u_src.pulse(8'h0, 8'h1 << k);
			rd("first", A_FST, 32'h1 << k);
			rd("next", A_NXT, 32'h100 << k);
			wr(A_FST, 32'h0);
			rd("first kept", A_FST, 32'h1 << k);
			wr(A_FST, 32'hFFFF);
			wr(A_NXT, 32'hFFFF);
			rd("first clr", A_FST, 32'h0);
			rd("next clr", A_NXT, 32'h0);
		end
	endtask
	task t_same;
		u_src.pulse(8'h03, 8'h81);
		u_src.pulse(8'h04, 8'h00);
		rd("first", A_FST, 32'h8103);
		rd("next", A_NXT, 32'h0004);
		wr(A_FST, 32'hFFFF);
		wr(A_NXT, 32'hFFFF);
	endtask
	task t_mask;
		for (int k = 0; k < 8; k++) begin
			wr(A_MSK, 32'h1 << k);
			u_src.pulse(8'hFF, 8'hFF);
			rd("masked", A_FST, {16'h0, {2{~(8'h1 << k)}}});
			rd("next", A_NXT, 32'h0);
			wr(A_FST, 32'hFFFF);
		end
		wr(A_MSK, 32'h0);
	endtask
	task t_thresh;
		wr(A_THR, 32'h5);
		u_src.set_count(16'h5, 16'h6);
		rd("thresh", A_FST, 32'h0800);
		wr(A_FST, 32'hFFFF);
	endtask
	// Bus reset must not touch the sticky logs and mask
	task t_sticky;
		wr(A_MSK, 32'h80);
		wr(A_MCE, 32'h0F);
		u_src.pulse(8'h01, 8'h00);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd("mask", A_MSK, 32'h80);
		rd("first", A_FST, 32'h0001);
		rd("next", A_NXT, 32'h0);
		rd("mce_en", A_MCE, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		t_reset();
		t_mce();
		t_events();
		t_same();
		t_mask();
		t_thresh();
		t_sticky();
		tally_and_finish();
	end
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
endmodule
